/* shared/butt_pkg.sv */
package butt_pkg;
    // register byte offsets
    localparam logic [5:0] OFS_CONTROL_ONE = 6'h00;
    localparam logic [5:0] OFS_CONTROL_TWO = 6'h04;
    localparam logic [5:0] OFS_IRQ_DMA_ENABLE = 6'h0C;
    localparam logic [5:0] OFS_TIMER_FLAGS = 6'h10;
    localparam logic [5:0] OFS_EVENT_TRIGGER = 6'h14;
    localparam logic [5:0] OFS_COUNT_VALUE = 6'h24;
    localparam logic [5:0] OFS_DIVIDER_VALUE = 6'h28;
    localparam logic [5:0] OFS_WRAP_LIMIT = 6'h2C;
    localparam logic [5:0] OFS_IRQ_MASK = 6'h30;
    // control_one bit positions
    localparam int RUN_ENABLE_POS = 0;
    localparam int UPDATE_INHIBIT_POS = 1;
    localparam int UPDATE_SOURCE_POS = 2;
    localparam int WRAP_PRELOAD_POS = 7;
    // irq_dma_enable bit positions
    localparam int UPDATE_IRQ_EN_POS = 0;
    localparam int UPDATE_DMA_EN_POS = 8;
    // status, trigger bit positions
    localparam int UPDATE_FLAG_POS = 0;
    localparam int FORCE_UPDATE_POS = 0;
    // writable masks
    localparam logic [15:0] CONTROL_ONE_MASK = 16'h0087;
    localparam logic [15:0] CONTROL_TWO_MASK = 16'h0070;
    localparam logic [15:0] IRQ_DMA_MASK = 16'h0101;
    localparam logic [15:0] FLAGS_MASK = 16'h0001;
    // reset values and the count step
    localparam logic [15:0] ZERO_RESET = 16'h0000;
    localparam logic [15:0] WRAP_LIMIT_RESET = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    // master trigger selections held in control_two
    localparam logic [2:0] MTO_RESET = 3'h0;
    localparam logic [2:0] MTO_ENABLE = 3'h1;
    localparam logic [2:0] MTO_UPDATE = 3'h2;
    localparam int MTO_LSB = 4;
endpackage

/* rtl/butt_timer.sv */
// Local design decision: the APB register port.
`timescale 1ns/10ps
// How it works
// [R01] counter is 16-bit, counts up only
// [R02] only internal clock drives the timer
// [R03] counter, reload, divider are 16-bit registers
// [R04] divide ratio is divider value plus one
// [R05] divider value buffered, applied at update
// [R06] run enable bit gates prescaler and counter
// [R07] count to wrap limit, restart, overrun
// [R08] update copies buffered reload and divider
// [R09] update inhibit suppresses all update events
// [R10] update raises irq or dma when enabled
// [R11] dma request issued on update when enabled
// [R12] registers at fixed offsets, 16-bit wide
// [R13] source select limits requests to overrun
// [R14] reload preload defers write to update
// [R15] update flag set by hardware, software clears
// [R16] force update zeroes counter, prescaler, updates
// [R17] interrupt line while flag and enable set; this design also needs the mask bit set
//
// one clock, one reset, an apb slave for software
// the bus answers with no wait state
// reads come from a register loaded in the setup cycle
// unmapped or misaligned offsets raise pslverr
// writes to unmapped offsets change nothing
// the prescaler counts kernel clocks up to its working divider
// a prescaler wrap is one counter tick
// the counter wraps to zero after the working limit
// a wrap, a forced update or a slave request is an update
// the inhibit bit blocks every update source
// an update copies buffered divider and limit to working copies
// the source select bit keeps only wraps as requests
// a request sets the sticky flag and may pulse dma
// the flag clears when software writes a one to it
// a set in the same cycle as a clear wins
// the interrupt line needs flag, mask and enable
// the mask register sits at the offset after the limit
// the master trigger output follows control_two bits 6 to 4
// limitation: reads and writes use the low two byte lanes only
module butt_timer
(
    // kernel and bus clock
    input wire logic pclk,
    // asynchronous reset, active low
    input wire logic presetn,
    // slave select
    input wire logic psel,
    // access phase marker
    input wire logic penable,
    // direction, high for write
    input wire logic pwrite,
    // byte address
    input wire logic [31:0] paddr,
    // write data
    input wire logic [31:0] pwdata,
    // byte lane strobes
    input wire logic [3:0] pstrb,
    // read data, registered
    output logic [31:0] prdata,
    // always ready
    output logic pready,
    // error on unmapped access
    output logic pslverr,
    // one-cycle update request from a slave controller
    input wire logic slave_update, // update request from a slave controller
    // level interrupt
    output logic irq,
    // one-cycle dma request pulse
    output logic dma_req,
    // trigger towards other timers
    output logic master_trigger_out
);
    // 16-bit data path, one clock domain only [R02]
    // run, inhibit, source select and preload bits
    logic [15:0] control_one_reg;
    // master trigger selection
    logic [15:0] control_two_reg;
    // interrupt and dma enables
    logic [15:0] irq_dma_enable_reg;
    // status bits
    logic [15:0] flags_reg; // sticky update flag
    // same layout as the status bits
    logic [15:0] irq_mask_reg; // gate of the interrupt line
    // the up counter
    logic [15:0] count_value_reg; // [R03]
    // software copy of the divider
    logic [15:0] divider_value_reg; // buffered divider
    // copy the prescaler compares against
    logic [15:0] divider_active_reg; // working divider
    // software copy of the limit
    logic [15:0] wrap_limit_reg; // buffered reload
    // copy the counter compares against
    logic [15:0] wrap_active_reg; // working reload
    // kernel clocks seen since the last tick
    logic [15:0] prescale_count_reg; // internal divider count
    // dma request flop
    logic dma_req_reg;
    // master trigger flop
    logic mto_reg;
    // read data flop
    logic [31:0] prdata_reg;

    // bus decode
    // access phase of a transfer
    wire logic access = psel && penable;
    // write access
    wire logic wr = access && pwrite;
    // read access
    wire logic rd = access && !pwrite;
    // offset inside the block
    wire logic [5:0] ofs = paddr[5:0];
    // control_one selected
    wire logic hit_ctl1 = ofs == butt_pkg::OFS_CONTROL_ONE; // [R12]
    // control_two selected
    wire logic hit_ctl2 = ofs == butt_pkg::OFS_CONTROL_TWO;
    // irq_dma_enable selected
    wire logic hit_ien = ofs == butt_pkg::OFS_IRQ_DMA_ENABLE;
    // timer_flags selected
    wire logic hit_sts = ofs == butt_pkg::OFS_TIMER_FLAGS;
    // event_trigger selected
    wire logic hit_ceg = ofs == butt_pkg::OFS_EVENT_TRIGGER;
    // count_value selected
    wire logic hit_cnt = ofs == butt_pkg::OFS_COUNT_VALUE;
    // divider_value selected
    wire logic hit_psc = ofs == butt_pkg::OFS_DIVIDER_VALUE;
    // wrap_limit selected
    wire logic hit_arr = ofs == butt_pkg::OFS_WRAP_LIMIT;
    // interrupt mask selected
    wire logic hit_msk = ofs == butt_pkg::OFS_IRQ_MASK;
    // aligned word inside the block window
    wire logic in_range = paddr[31:6] == 26'h0000000 && paddr[1:0] == 2'h0;
    wire logic mapped = in_range && (hit_ctl1 || hit_ctl2 || hit_ien || hit_sts || hit_ceg
                                     || hit_cnt || hit_psc || hit_arr || hit_msk);

    // merge the low two byte lanes of a write into a 16-bit value
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st);
        merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction

    wire logic [15:0] wdata16 = merge16(16'h0000, pwdata, pstrb);

    // register write strobes
    // refused writes never reach a register
    wire logic wr_ok = wr && mapped;
    // control_one write
    wire logic wr_ctl1 = wr_ok && hit_ctl1;
    // control_two write
    wire logic wr_ctl2 = wr_ok && hit_ctl2;
    // enable write
    wire logic wr_ien = wr_ok && hit_ien;
    // flag clear write
    wire logic wr_sts = wr_ok && hit_sts;
    // event trigger write
    wire logic wr_ceg = wr_ok && hit_ceg;
    // counter write
    wire logic wr_cnt = wr_ok && hit_cnt;
    // divider write
    wire logic wr_psc = wr_ok && hit_psc;
    // limit write
    wire logic wr_arr = wr_ok && hit_arr;
    // mask write
    wire logic wr_msk = wr_ok && hit_msk;

    // control bits
    // counting allowed
    wire logic run_enable_bit = control_one_reg[butt_pkg::RUN_ENABLE_POS];
    // all updates blocked
    wire logic update_inhibit = control_one_reg[butt_pkg::UPDATE_INHIBIT_POS];
    // only wraps make requests
    wire logic update_source_select = control_one_reg[butt_pkg::UPDATE_SOURCE_POS];
    // limit writes wait for an update
    wire logic wrap_preload_enable = control_one_reg[butt_pkg::WRAP_PRELOAD_POS];
    // interrupt on request
    wire logic update_irq_enable = irq_dma_enable_reg[butt_pkg::UPDATE_IRQ_EN_POS];
    // dma on request
    wire logic update_dma_enable = irq_dma_enable_reg[butt_pkg::UPDATE_DMA_EN_POS];
    // master trigger source
    wire logic [2:0] mto_sel = control_two_reg[butt_pkg::MTO_LSB +: 3];

    // force update request, write-one, never stored so reads as zero [R16]
    wire logic force_update_bit = wr_ceg && pwdata[butt_pkg::FORCE_UPDATE_POS] && pstrb[0];

    // prescaler: tick when internal count reaches working divider [R04] [R06]
    // prescaler has seen divider plus one clocks
    wire logic prescale_wrap = prescale_count_reg == divider_active_reg;
    // a tick only while running, so a stopped timer holds
    wire logic counter_tick = run_enable_bit && prescale_wrap;
    // overrun when counter equals working reload on a tick [R07]
    wire logic at_limit = count_value_reg == wrap_active_reg;
    wire logic overrun = counter_tick && at_limit;

    // update event sources, all blocked by inhibit [R09]
    // a forced update still zeroes the counter while inhibited
    wire logic update_event = !update_inhibit && (overrun || force_update_bit || slave_update);
    // requests are a subset of update events
    // request source filter for irq and dma [R13]
    wire logic update_request = update_source_select ? (!update_inhibit && overrun) : update_event;

    // control registers and enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_one_reg <= butt_pkg::ZERO_RESET;
            control_two_reg <= butt_pkg::ZERO_RESET;
            irq_dma_enable_reg <= butt_pkg::ZERO_RESET;
            irq_mask_reg <= butt_pkg::ZERO_RESET;
        end
        else
        begin
            // writable bits only; reserved bits read zero
            // run, inhibit, source and preload bits
            if (wr_ctl1)
                control_one_reg <= merge16(control_one_reg, pwdata, pstrb) & butt_pkg::CONTROL_ONE_MASK;
            // master trigger selection
            if (wr_ctl2)
                control_two_reg <= merge16(control_two_reg, pwdata, pstrb) & butt_pkg::CONTROL_TWO_MASK;
            // interrupt and dma enables
            if (wr_ien)
                irq_dma_enable_reg <= merge16(irq_dma_enable_reg, pwdata, pstrb) & butt_pkg::IRQ_DMA_MASK;
            // interrupt mask
            if (wr_msk)
                irq_mask_reg <= merge16(irq_mask_reg, pwdata, pstrb) & butt_pkg::FLAGS_MASK;
        end
    end

    // sticky update flag: write one clears, a new set wins [R15]
    // every request sets the flag, enabled or not [R15]
    wire logic [15:0] flag_set = {15'h0000, update_request};
    // write-one clear on the writable bits only
    wire logic [15:0] flag_clr = wr_sts ? (wdata16 & butt_pkg::FLAGS_MASK) : butt_pkg::ZERO_RESET;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_reg <= butt_pkg::ZERO_RESET;
        // clear first, then the set, so a set in the same cycle wins
        else
            flags_reg <= (flags_reg & ~flag_clr) | flag_set; // [R15]
    end

    // buffered divider and reload, with active copies [R05] [R08] [R14]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            divider_value_reg <= butt_pkg::ZERO_RESET;
            divider_active_reg <= butt_pkg::ZERO_RESET;
            wrap_limit_reg <= butt_pkg::WRAP_LIMIT_RESET;
            wrap_active_reg <= butt_pkg::WRAP_LIMIT_RESET;
        end
        else
        begin
            // software divider copy
            if (wr_psc)
                divider_value_reg <= merge16(divider_value_reg, pwdata, pstrb);
            // software limit copy
            if (wr_arr)
                wrap_limit_reg <= merge16(wrap_limit_reg, pwdata, pstrb);
            // update loads active copies from the buffers [R08] [R05]
            if (update_event)
            begin
                divider_active_reg <= divider_value_reg;
                wrap_active_reg <= wrap_limit_reg;
            end
            // without preload a reload write acts at once [R14]
            // placed last so a same-cycle write beats the update copy
            if (wr_arr && !wrap_preload_enable)
                wrap_active_reg <= merge16(wrap_limit_reg, pwdata, pstrb);
        end
    end

    // prescaler counter, cleared by force update [R04] [R16]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prescale_count_reg <= butt_pkg::ZERO_RESET;
        // forced update restarts the division
        else if (force_update_bit)
            prescale_count_reg <= butt_pkg::ZERO_RESET; // [R16]
        // stopped timer keeps its partial count
        else if (run_enable_bit) // [R06]
            prescale_count_reg <= prescale_wrap ? butt_pkg::ZERO_RESET : prescale_count_reg + butt_pkg::COUNT_ONE;
    end

    // up counter: zero on force or overrun, else add one per tick [R01] [R07]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_value_reg <= butt_pkg::ZERO_RESET;
        // forced update beats everything
        else if (force_update_bit)
            count_value_reg <= butt_pkg::ZERO_RESET; // [R16]
        // software write beats counting
        else if (wr_cnt)
            count_value_reg <= merge16(count_value_reg, pwdata, pstrb);
        // wrap at the working limit
        else if (overrun)
            count_value_reg <= butt_pkg::ZERO_RESET; // [R07]
        // plain count, never down
        else if (counter_tick)
            count_value_reg <= count_value_reg + butt_pkg::COUNT_ONE; // [R01]
    end

    // dma request pulse and master trigger output [R10] [R11]
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dma_req_reg <= 1'b0;
            mto_reg <= 1'b0;
        end
        else
        begin
            // one pulse per request while enabled
            dma_req_reg <= update_request && update_dma_enable; // [R11]
            // trigger source chosen by software
            unique case (mto_sel)
                // forced update pulse
                butt_pkg::MTO_RESET: mto_reg <= force_update_bit;
                // run level
                butt_pkg::MTO_ENABLE: mto_reg <= run_enable_bit;
                // update pulse
                butt_pkg::MTO_UPDATE: mto_reg <= update_event;
                // unused selections stay low
                default: mto_reg <= 1'b0;
            endcase
        end
    end

    // read mux
    // event_trigger and holes read zero
    wire logic [15:0] rd16 = hit_ctl1 ? control_one_reg :
                             hit_ctl2 ? control_two_reg :
                             hit_ien ? irq_dma_enable_reg :
                             hit_sts ? flags_reg :
                             hit_cnt ? count_value_reg :
                             hit_psc ? divider_value_reg :
                             hit_arr ? wrap_limit_reg :
                             hit_msk ? irq_mask_reg : butt_pkg::ZERO_RESET;

    // read data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h00000000;
        // loaded in the setup cycle, stands through the access cycle
        else if (psel && !penable && !pwrite)
            prdata_reg <= {16'h0000, rd16};
    end

    // outputs: zero wait state, error on unmapped
    // registered read data
    assign prdata = prdata_reg;
    // no wait states
    assign pready = 1'b1;
    // error only in the access cycle
    assign pslverr = access && !mapped;
    // interrupt needs enable, flag and mask
    assign irq = update_irq_enable && (|(flags_reg & irq_mask_reg)); // [R17] [R10]
    // dma pulse
    assign dma_req = dma_req_reg;
    // trigger flop
    assign master_trigger_out = mto_reg;
endmodule // butt_timer

/* tb/butt_timer_chk.sv */
`timescale 1ns/10ps
// watches the register bus and the request outputs of the timer
module butt_timer_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic slave_update,
    input wire logic irq,
    input wire logic dma_req,
    input wire logic master_trigger_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // access phase of a bus transfer
    wire logic acc = psel && penable;
    // write into the low byte lane of a register
    wire logic wr_lo = acc && pwrite && pstrb[0];
    pready_high_a: assert property (pready) else $error("bus not ready");
    err_access_a: assert property (pslverr |-> acc) else $error("error outside access");
    unmapped_err_a: assert property (acc && paddr[5:0] == 6'h08 |-> pslverr) else $error("hole accepted");
    mapped_ok_a: assert property (acc && paddr[5:0] == butt_pkg::OFS_WRAP_LIMIT |-> !pslverr)
        else $error("register refused");
    upper_zero_a: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000) else $error("upper half set");
    trig_read_a: assert property (acc && !pwrite && paddr[5:0] == butt_pkg::OFS_EVENT_TRIGGER |-> prdata == 32'h0)
        else $error("trigger reads back");
    mask_off_a: assert property (wr_lo && paddr[5:0] == butt_pkg::OFS_IRQ_MASK && !pwdata[0] |=> !irq)
        else $error("masked irq high");
    dma_off_a: assert property (acc && pwrite && pstrb[1] && paddr[5:0] == butt_pkg::OFS_IRQ_DMA_ENABLE
        && !pwdata[8] |-> ##2 !dma_req) else $error("dma while disabled");
    // main scenarios reached
    cover property (acc && pslverr);
    cover property ($rose(irq));
    cover property (dma_req);
endmodule // butt_timer_chk

/* tb/butt_timer_tb.sv */
`timescale 1ns/10ps
// drives the timer over its register bus and judges the replies
module butt_timer_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slave_update = 0;
    logic [31:0] paddr = 0, pwdata = 0, rd;
    logic [3:0] pstrb = 4'hF;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq, dma_req, master_trigger_out;
    int mismatches = 0, checks_done = 0, dma_cnt = 0;
    logic err;
    butt_timer i_butt_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slave_update(slave_update), .irq(irq), .dma_req(dma_req), .master_trigger_out(master_trigger_out));
    // 25 MHz clock
    always #20 pclk = ~pclk;
    // counts request pulses
    always @(posedge pclk) if (dma_req === 1'b1) dma_cnt++;
    // compare and report
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus transfer, held until ready
    task apb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= {26'h0, a}; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task rdchk(input logic [5:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask
    // reset values and the hole in the map
    task t_reset;
        rdchk(butt_pkg::OFS_CONTROL_ONE, 32'h0);
        rdchk(butt_pkg::OFS_WRAP_LIMIT, 32'hFFFF);
        rdchk(butt_pkg::OFS_COUNT_VALUE, 32'h0);
        rdchk(6'h08, 32'h0);
        chk(err, 1'b1);
    endtask
    // short wrap raises the flag and the irq
    task t_wrap;
        apb(1, butt_pkg::OFS_IRQ_MASK, 32'h1);
        apb(1, butt_pkg::OFS_IRQ_DMA_ENABLE, 32'h1);
        apb(1, butt_pkg::OFS_WRAP_LIMIT, 32'h3);
        apb(1, butt_pkg::OFS_CONTROL_ONE, 32'h1);
        repeat (40) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1, butt_pkg::OFS_CONTROL_ONE, 32'h0);
        rdchk(butt_pkg::OFS_TIMER_FLAGS, 32'h1);
        apb(1, butt_pkg::OFS_TIMER_FLAGS, 32'h1);
        @(posedge pclk);
        chk(irq, 1'b0);
    endtask
    // inhibit, forced update and source select
    task t_force;
        apb(1, butt_pkg::OFS_CONTROL_ONE, 32'h2);
        apb(1, butt_pkg::OFS_EVENT_TRIGGER, 32'h1);
        rdchk(butt_pkg::OFS_TIMER_FLAGS, 32'h0);
        apb(1, butt_pkg::OFS_CONTROL_ONE, 32'h0);
        apb(1, butt_pkg::OFS_COUNT_VALUE, 32'h5);
        apb(1, butt_pkg::OFS_EVENT_TRIGGER, 32'h1);
        rdchk(butt_pkg::OFS_TIMER_FLAGS, 32'h1);
        rdchk(butt_pkg::OFS_COUNT_VALUE, 32'h0);
        apb(1, butt_pkg::OFS_TIMER_FLAGS, 32'h1);
        apb(1, butt_pkg::OFS_CONTROL_ONE, 32'h4);
        apb(1, butt_pkg::OFS_EVENT_TRIGGER, 32'h1);
        rdchk(butt_pkg::OFS_TIMER_FLAGS, 32'h0);
    endtask
    // slave update requests a transfer
    task t_dma;
        apb(1, butt_pkg::OFS_CONTROL_ONE, 32'h0);
        apb(1, butt_pkg::OFS_IRQ_DMA_ENABLE, 32'h101);
        dma_cnt = 0;
        @(posedge pclk) slave_update <= 1;
        @(posedge pclk) slave_update <= 0;
        repeat (4) @(posedge pclk);
        chk(dma_cnt, 1);
        rdchk(butt_pkg::OFS_TIMER_FLAGS, 32'h1);
        apb(1, butt_pkg::OFS_TIMER_FLAGS, 32'h1);
        apb(1, butt_pkg::OFS_IRQ_DMA_ENABLE, 32'h0);
        apb(1, butt_pkg::OFS_IRQ_MASK, 32'h0);
    endtask
    // divide by two after the buffered value is loaded
    task t_presc;
        logic [31:0] c1;
        apb(1, butt_pkg::OFS_WRAP_LIMIT, 32'hFFFF);
        apb(1, butt_pkg::OFS_DIVIDER_VALUE, 32'h1);
        apb(1, butt_pkg::OFS_EVENT_TRIGGER, 32'h1);
        apb(1, butt_pkg::OFS_CONTROL_TWO, 32'h10);
        apb(1, butt_pkg::OFS_CONTROL_ONE, 32'h1);
        apb(0, butt_pkg::OFS_COUNT_VALUE, 0);
        c1 = rd;
        chk(master_trigger_out, 1'b1);
        repeat (16) @(posedge pclk);
        apb(0, butt_pkg::OFS_COUNT_VALUE, 0);
        chk((rd - c1 >= 9 && rd - c1 <= 11), 1'b1);
        apb(1, butt_pkg::OFS_CONTROL_ONE, 32'h0);
        apb(0, butt_pkg::OFS_COUNT_VALUE, 0);
        c1 = rd;
        rdchk(butt_pkg::OFS_COUNT_VALUE, c1);
        chk(master_trigger_out, 1'b0);
    endtask
    // verdict and end of run
    task final_report;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_wrap();
        t_force();
        t_dma();
        t_presc();
        final_report();
    end
    // watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge pclk);
        mismatches++;
        final_report();
    end
endmodule // butt_timer_tb
bind butt_timer butt_timer_chk i_butt_timer_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slave_update(slave_update), .irq(irq), .dma_req(dma_req),
    .master_trigger_out(master_trigger_out));
